// ==== logic/capcal_top.sv ====
// Configuration decode, conversion timing and calibration datapath of the capacitive front end
//
// Local design decision: the address-and-strobe port.
`include "capcal_defs.svh"

// Function
// - Offset-shift capacitance comes from bits 5:0 of word 0x12.
// - Span from bits 13:9 of 0x12; usable range is twice coded span.
// - Bit 15 of 0x12 zero selects differential measurement, the default.
// - Bit 15 one selects single-ended; reference electrode grounded unless bit 4 or bit 3 of 0x19 is set.
// - Bit 14 enables leakage compensation in single-ended; span doubles.
// - Bit 4 of 0x19 makes reference follow sense electrode (guard drive) in single-ended only.
// - Bit 3 of 0x19 charges reference oppositely for difference measurement in single-ended, when bit 4 is clear.
// - Temperature always converts at 14-bit resolution.
// - Bits 7:6 of 0x12 pick 12/14/16/18 bit resolution; default 16.
// - Bit 8 of 0x12 picks high noise mode, longer conversion.
// - Conversion times per resolution and noise mode as tabulated.
// - Datapath values are 26-bit two's complement.
// - Coefficients are sign-magnitude, 1 sign over 23-bit magnitude.
// - Every product is scaled down by 2^23.
// - Overflow saturates at range limit and sets status flag.
// - Reciprocal step only on compensated measurements, never raw requests.
// - Bit 11 of 0x02 enables reciprocal pre-compensation.
// - Reciprocal result is 2^24 - 2^46/raw, saturated to 26 bits.
// - Bits 1:0 of 0x19 hold the pin choice; only bit 0 picks the sense electrode pin.
// - 24-bit coefficient shifted left two places into 26-bit register.
module capcal_top (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic [7:0]  addr,
  input  wire logic [15:0] wdata,
  input  wire logic        wr_en,
  input  wire logic        rd_en,
  output logic [15:0]      rdata,
  output capcal_pkg::capcal_pins_t pins,
  output capcal_pkg::capcal_cfg_t  cfg_active,
  output logic             busy,
  output logic             done
);

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic [15:0]              calopt_q;
  logic [15:0]              frontend_q;
  logic [15:0]              submode_q;
  logic [23:0]              raw_q;
  logic [23:0]              coef_q;
  logic signed [25:0]       res_q;
  logic                     sat_q;
  logic                     raw_mode_q;
  capcal_pkg::capcal_cfg_t  cfg_q;
  capcal_pkg::capcal_cfg_t  cfg_d;
  logic [21:0]              cnt_q;
  logic [21:0]              conv_cycles;
  logic                     start_req;
  logic                     raw_req;

  typedef enum logic [1:0] {
    CAPCAL_IDLE,
    CAPCAL_CONV_SENSOR,
    CAPCAL_CONV_TEMP,
    CAPCAL_MATH
  } capcal_state_t;

  capcal_state_t state_q;

  assign start_req = wr_en && (addr == `CAPCAL_OFS_CTRL) && wdata[`CAPCAL_CTRL_START];
  assign raw_req   = wdata[`CAPCAL_CTRL_RAWREQ];

  // ****************************************************************
  // Configuration words
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      calopt_q   <= `CAPCAL_RST_CALOPT;
      frontend_q <= `CAPCAL_RST_FRONTEND;
      submode_q  <= `CAPCAL_RST_SUBMODE;
    end else if (wr_en) begin
      case (addr)
        `CAPCAL_OFS_CALOPT:   calopt_q   <= wdata;
        `CAPCAL_OFS_FRONTEND: frontend_q <= wdata;
        `CAPCAL_OFS_SUBMODE:  submode_q  <= wdata;
        default: ;
      endcase
    end
  end

  // Raw sample and coefficient, each written in two halves
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      raw_q  <= 24'h000000;
      coef_q <= 24'h000000;
    end else if (wr_en) begin
      case (addr)
        `CAPCAL_OFS_RAW_LO:  raw_q[15:0]   <= wdata;
        `CAPCAL_OFS_RAW_HI:  raw_q[23:16]  <= wdata[7:0];
        `CAPCAL_OFS_COEF_LO: coef_q[15:0]  <= wdata;
        `CAPCAL_OFS_COEF_HI: coef_q[23:16] <= wdata[7:0];
        default: ;
      endcase
    end
  end

  // ****************************************************************
  // Configuration decode
  // ****************************************************************
  always_comb begin
    cfg_d.shift_cap    = frontend_q[`CAPCAL_SHIFT_CAP_HI:`CAPCAL_SHIFT_CAP_LO];
    cfg_d.span         = frontend_q[`CAPCAL_SPAN_HI:`CAPCAL_SPAN_LO];
    cfg_d.single_ended = frontend_q[`CAPCAL_TOPO_BIT];
    cfg_d.leak_comp    = cfg_d.single_ended & frontend_q[`CAPCAL_LEAK_BIT];
    // One-polarity magnitude of the span, doubled with leakage comp
    cfg_d.span_eff     = cfg_d.leak_comp ? {cfg_d.span, 1'b0} : {1'b0, cfg_d.span};
    cfg_d.noise_high   = frontend_q[`CAPCAL_NOISE_BIT];
    cfg_d.sensor_res   = capcal_pkg::capcal_res_t'(
                           frontend_q[`CAPCAL_ADC_BITS_HI:`CAPCAL_ADC_BITS_LO]);
    cfg_d.temp_res     = capcal_pkg::CAPCAL_RES14;
    cfg_d.guard_drive_enable       = cfg_d.single_ended & submode_q[`CAPCAL_GUARD_BIT];
    cfg_d.difference_charge_enable = cfg_d.single_ended & submode_q[`CAPCAL_DIFFQ_BIT];
    cfg_d.electrode_pin_choice     = submode_q[`CAPCAL_PIN_HI:`CAPCAL_PIN_LO];
    cfg_d.reciprocal_en            = calopt_q[`CAPCAL_INV_BIT];
  end

  // Snapshot at start so writes mid-measurement wait for the next one
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cfg_q <= '0;
      cfg_q.sensor_res <= capcal_pkg::CAPCAL_RES16;
      cfg_q.temp_res   <= capcal_pkg::CAPCAL_RES14;
    end else if (start_req && state_q == CAPCAL_IDLE) begin
      cfg_q <= cfg_d;
    end
  end

  assign cfg_active = cfg_q;

  // ****************************************************************
  // Electrode steering
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pins <= '0;
    end else begin
      pins.sense_on_main      <= ~cfg_q.electrode_pin_choice[0];
      pins.sense_on_alternate <= cfg_q.electrode_pin_choice[0];
      pins.reference_grounded <= cfg_q.single_ended & ~cfg_q.guard_drive_enable
                                 & ~cfg_q.difference_charge_enable;
      pins.reference_follows_sense   <= cfg_q.guard_drive_enable;
      pins.reference_opposite_charge <= cfg_q.difference_charge_enable
                                        & ~cfg_q.guard_drive_enable;
    end
  end

  // ****************************************************************
  // Conversion timing
  // ****************************************************************
  always_comb begin
    conv_cycles = 22'h000001;
    if (state_q == CAPCAL_CONV_TEMP) begin
      conv_cycles = 22'(`CAPCAL_CYC(`CAPCAL_US_T_14));
    end else begin
      case ({cfg_q.noise_high, cfg_q.sensor_res})
        {1'b0, capcal_pkg::CAPCAL_RES12}: conv_cycles = 22'(`CAPCAL_CYC(`CAPCAL_US_S0_12));
        {1'b0, capcal_pkg::CAPCAL_RES14}: conv_cycles = 22'(`CAPCAL_CYC(`CAPCAL_US_S0_14));
        {1'b0, capcal_pkg::CAPCAL_RES16}: conv_cycles = 22'(`CAPCAL_CYC(`CAPCAL_US_S0_16));
        {1'b0, capcal_pkg::CAPCAL_RES18}: conv_cycles = 22'(`CAPCAL_CYC(`CAPCAL_US_S0_18));
        {1'b1, capcal_pkg::CAPCAL_RES12}: conv_cycles = 22'(`CAPCAL_CYC(`CAPCAL_US_S1_12));
        {1'b1, capcal_pkg::CAPCAL_RES14}: conv_cycles = 22'(`CAPCAL_CYC(`CAPCAL_US_S1_14));
        {1'b1, capcal_pkg::CAPCAL_RES16}: conv_cycles = 22'(`CAPCAL_CYC(`CAPCAL_US_S1_16));
        {1'b1, capcal_pkg::CAPCAL_RES18}: conv_cycles = 22'(`CAPCAL_CYC(`CAPCAL_US_S1_18));
        default:                          conv_cycles = 22'h000001;
      endcase
    end
  end

  // ****************************************************************
  // Measurement sequencer
  // ****************************************************************
  // Raw request kept for the whole measurement and its status
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      raw_mode_q <= 1'b0;
    end else if (start_req && state_q == CAPCAL_IDLE) begin
      raw_mode_q <= raw_req;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_q <= CAPCAL_IDLE;
      cnt_q   <= 22'h000000;
    end else begin
      case (state_q)
        CAPCAL_IDLE: begin
          cnt_q <= 22'h000000;
          if (start_req) begin
            state_q <= CAPCAL_CONV_SENSOR;
          end
        end
        CAPCAL_CONV_SENSOR: begin
          if (cnt_q >= conv_cycles - 22'h000001) begin
            cnt_q   <= 22'h000000;
            state_q <= CAPCAL_CONV_TEMP;
          end else begin
            cnt_q <= cnt_q + 22'h000001;
          end
        end
        CAPCAL_CONV_TEMP: begin
          if (cnt_q >= conv_cycles - 22'h000001) begin
            cnt_q   <= 22'h000000;
            state_q <= CAPCAL_MATH;
          end else begin
            cnt_q <= cnt_q + 22'h000001;
          end
        end
        CAPCAL_MATH: state_q <= CAPCAL_IDLE;
        default:     state_q <= CAPCAL_IDLE;
      endcase
    end
  end

  assign busy = (state_q != CAPCAL_IDLE);

  // One-cycle pulse in the cycle after the math step
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      done <= 1'b0;
    end else begin
      done <= (state_q == CAPCAL_MATH);
    end
  end

  // ****************************************************************
  // Calibration datapath
  // ****************************************************************
  logic signed [25:0] raw_ext;
  logic signed [25:0] coef_w;
  logic signed [25:0] recip_w;
  logic               recip_sat;
  logic signed [25:0] pre_w;
  logic signed [25:0] mul_w;
  logic               mul_sat;
  logic signed [47:0] quot;
  logic signed [47:0] recip_full;

  assign raw_ext = 26'(signed'(raw_q));

  // Sign-magnitude to two's complement, MSB aligned
  assign coef_w = coef_q[23] ? -$signed({1'b0, coef_q[22:0], 2'b00})
                             :  $signed({1'b0, coef_q[22:0], 2'b00});

  always_comb begin
    quot       = 48'sh0;
    recip_full = 48'sh0;
    recip_w    = 26'sh0;
    recip_sat  = 1'b0;
    if (raw_ext == 26'sh0) begin
      recip_w   = -26'sh2000000;
      recip_sat = 1'b1;
    end else begin
      quot       = (48'sh1 <<< 46) / 48'(raw_ext);
      recip_full = (48'sh1 <<< 24) - quot;
      if (recip_full > 48'sh1FFFFFF) begin
        recip_w   = 26'sh1FFFFFF;
        recip_sat = 1'b1;
      end else if (recip_full < -48'sh2000000) begin
        recip_w   = -26'sh2000000;
        recip_sat = 1'b1;
      end else begin
        recip_w = recip_full[25:0];
      end
    end
  end

  // Raw requests bypass inversion
  assign pre_w = (cfg_q.reciprocal_en && !raw_mode_q) ? recip_w : raw_ext;

  capcal_sat_mul u_mul (
    .a   (pre_w),
    .b   (coef_w),
    .y   (mul_w),
    .sat (mul_sat)
  );

  // ****************************************************************
  // Result and saturation flag
  // ****************************************************************
  // Raw requests return the sample untouched
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      res_q <= 26'sh0;
    end else if (state_q == CAPCAL_MATH) begin
      res_q <= raw_mode_q ? raw_ext : mul_w;
    end
  end

  // Sticky; a saturating result beats a clear in the same cycle
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sat_q <= 1'b0;
    end else if (state_q == CAPCAL_MATH) begin
      if (!raw_mode_q && (mul_sat || (cfg_q.reciprocal_en && recip_sat))) begin
        sat_q <= 1'b1;
      end
    end else if (wr_en && addr == `CAPCAL_OFS_CTRL && wdata[`CAPCAL_CTRL_CLRSAT]) begin
      sat_q <= 1'b0;
    end
  end

  // ****************************************************************
  // Read port
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdata <= 16'h0000;
    end else if (rd_en) begin
      case (addr)
        `CAPCAL_OFS_CALOPT:   rdata <= calopt_q;
        `CAPCAL_OFS_FRONTEND: rdata <= frontend_q;
        `CAPCAL_OFS_SUBMODE:  rdata <= submode_q;
        `CAPCAL_OFS_STATUS:   rdata <= {13'h0000, raw_mode_q, sat_q, busy};
        `CAPCAL_OFS_RAW_LO:   rdata <= raw_q[15:0];
        `CAPCAL_OFS_RAW_HI:   rdata <= {8'h00, raw_q[23:16]};
        `CAPCAL_OFS_COEF_LO:  rdata <= coef_q[15:0];
        `CAPCAL_OFS_COEF_HI:  rdata <= {8'h00, coef_q[23:16]};
        `CAPCAL_OFS_RES_LO:   rdata <= res_q[15:0];
        `CAPCAL_OFS_RES_HI:   rdata <= {6'h00, res_q[25:16]};
        `CAPCAL_OFS_ACTIVE:   rdata <= {cfg_q.single_ended, cfg_q.leak_comp, cfg_q.span_eff,
                                        cfg_q.noise_high, cfg_q.sensor_res,
                                        cfg_q.guard_drive_enable,
                                        cfg_q.difference_charge_enable,
                                        cfg_q.reciprocal_en, cfg_q.electrode_pin_choice};
        default:              rdata <= 16'h0000;
      endcase
    end else begin
      rdata <= 16'h0000;
    end
  end

endmodule : capcal_top

// ==== logic/capcal_defs.svh ====
// Register offsets, field positions, reset values and timing counts of the capacitive front end
`ifndef CAPCAL_DEFS_SVH
`define CAPCAL_DEFS_SVH

// ****************************************************************
// Register map
// ****************************************************************
`define CAPCAL_ADDR_W          8
`define CAPCAL_OFS_CALOPT      8'h02
`define CAPCAL_OFS_FRONTEND    8'h12
`define CAPCAL_OFS_SUBMODE     8'h19
`define CAPCAL_OFS_CTRL        8'h20
`define CAPCAL_OFS_STATUS      8'h21
`define CAPCAL_OFS_RAW_LO      8'h22
`define CAPCAL_OFS_RAW_HI      8'h23
`define CAPCAL_OFS_COEF_LO     8'h24
`define CAPCAL_OFS_COEF_HI     8'h25
`define CAPCAL_OFS_RES_LO      8'h26
`define CAPCAL_OFS_RES_HI      8'h27
`define CAPCAL_OFS_ACTIVE      8'h28

// ****************************************************************
// Reset values
// ****************************************************************
`define CAPCAL_RST_CALOPT      16'h0000
`define CAPCAL_RST_FRONTEND    16'h0080
`define CAPCAL_RST_SUBMODE     16'h0000

// ****************************************************************
// Field positions
// ****************************************************************
`define CAPCAL_SHIFT_CAP_HI    5
`define CAPCAL_SHIFT_CAP_LO    0
`define CAPCAL_ADC_BITS_HI     7
`define CAPCAL_ADC_BITS_LO     6
`define CAPCAL_NOISE_BIT       8
`define CAPCAL_SPAN_HI         13
`define CAPCAL_SPAN_LO         9
`define CAPCAL_LEAK_BIT        14
`define CAPCAL_TOPO_BIT        15
`define CAPCAL_PIN_HI          1
`define CAPCAL_PIN_LO          0
`define CAPCAL_DIFFQ_BIT       3
`define CAPCAL_GUARD_BIT       4
`define CAPCAL_INV_BIT         11
`define CAPCAL_CTRL_START      0
`define CAPCAL_CTRL_RAWREQ     1
`define CAPCAL_CTRL_CLRSAT     2
`define CAPCAL_CTRL_MUL        3

// ****************************************************************
// Timing
// ****************************************************************
`define CAPCAL_CLK_MHZ         250
`define CAPCAL_TEMP_BITS       14
`define CAPCAL_US_S0_12        770
`define CAPCAL_US_S0_14        1310
`define CAPCAL_US_S0_16        2390
`define CAPCAL_US_S0_18        4550
`define CAPCAL_US_S1_12        1550
`define CAPCAL_US_S1_14        2850
`define CAPCAL_US_S1_16        5440
`define CAPCAL_US_S1_18        10620
`define CAPCAL_US_T_12         630
`define CAPCAL_US_T_14         1040
`define CAPCAL_US_T_16         1810
`define CAPCAL_US_T_18         3470
`define CAPCAL_CYC(us)         ((us) * `CAPCAL_CLK_MHZ)

`endif

// ==== logic/capcal_pkg.sv ====
// Types of the capacitive front end configuration and calibration datapath
package capcal_pkg;

  typedef logic signed [25:0] capcal_word_t;

  typedef enum logic [1:0] {
    CAPCAL_RES12,
    CAPCAL_RES14,
    CAPCAL_RES16,
    CAPCAL_RES18
  } capcal_res_t;

  typedef struct packed {
    logic [5:0]  shift_cap;
    logic [4:0]  span;
    logic [5:0]  span_eff;
    logic        single_ended;
    logic        leak_comp;
    logic        noise_high;
    capcal_res_t sensor_res;
    capcal_res_t temp_res;
    logic        guard_drive_enable;
    logic        difference_charge_enable;
    logic [1:0]  electrode_pin_choice;
    logic        reciprocal_en;
  } capcal_cfg_t;

  typedef struct packed {
    logic        sense_on_main;
    logic        sense_on_alternate;
    logic        reference_grounded;
    logic        reference_follows_sense;
    logic        reference_opposite_charge;
  } capcal_pins_t;

endpackage : capcal_pkg

// ==== logic/capcal_sat_mul.sv ====
// Fixed-point multiply of two 26-bit words, scaled down by 2^23 and saturated
`include "capcal_defs.svh"

module capcal_sat_mul (
  input  wire logic signed [25:0] a,
  input  wire logic signed [25:0] b,
  output logic signed [25:0]      y,
  output logic                    sat
);

  logic signed [51:0] prod;
  logic signed [28:0] scaled;

  assign prod   = a * b;
  assign scaled = prod[51:23];

  always_comb begin
    if (scaled > 29'sh1FFFFFF) begin
      y   = 26'sh1FFFFFF;
      sat = 1'b1;
    end else if (scaled < -29'sh2000000) begin
      y   = -26'sh2000000;
      sat = 1'b1;
    end else begin
      y   = scaled[25:0];
      sat = 1'b0;
    end
  end

endmodule : capcal_sat_mul

// ==== dv/capcal_sensor_model.sv ====
// Electrode side model that flags impossible pin drive combinations
module capcal_sensor_model (
  input  wire logic                     clk,
  input  wire logic                     sys_rst,
  input  wire capcal_pkg::capcal_pins_t pins,
  output logic                          conflict_q
);
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************************************
  // Sticky conflict flag
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      conflict_q <= 1'b0;
    end else if ((pins.sense_on_main && pins.sense_on_alternate) ||
                 (pins.reference_grounded && pins.reference_follows_sense) ||
                 (pins.reference_follows_sense && pins.reference_opposite_charge)) begin
      conflict_q <= 1'b1;
    end
  end
endmodule : capcal_sensor_model

// ==== dv/capcal_top_assertions.sv ====
// Concurrent checks on the ports of the capacitive front end top
`include "capcal_defs.svh"
module capcal_top_assertions (
  input  wire logic                     clk,
  input  wire logic                     sys_rst,
  input  wire logic [7:0]               addr,
  input  wire logic [15:0]              wdata,
  input  wire logic                     wr_en,
  input  wire logic                     rd_en,
  input  wire logic [15:0]              rdata,
  input  wire capcal_pkg::capcal_pins_t pins,
  input  wire capcal_pkg::capcal_cfg_t  cfg_active,
  input  wire logic                     busy,
  input  wire logic                     done
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  AST_RESET_RES: assert property ($fell(sys_rst) |->
    cfg_active.sensor_res == capcal_pkg::CAPCAL_RES16 && !busy && !done)
    else $error("Default resolution or idle state wrong after reset");
  AST_TEMP_RES: assert property (cfg_active.temp_res == capcal_pkg::CAPCAL_RES14)
    else $error("Temperature resolution not 14 bit");
  AST_SPAN_EFF: assert property (cfg_active.span_eff ==
    (cfg_active.leak_comp ? {cfg_active.span, 1'b0} : {1'b0, cfg_active.span}))
    else $error("Effective span not derived from span and leakage option");
  AST_CFG_STATIC: assert property (busy ##1 busy |-> $stable(cfg_active))
    else $error("Active configuration changed during measurement");
  AST_PIN_CHOICE: assert property (!sys_rst |=>
    pins.sense_on_alternate == $past(cfg_active.electrode_pin_choice[0]) &&
    pins.sense_on_main == !$past(cfg_active.electrode_pin_choice[0]))
    else $error("Sense electrode choice wrong");
  AST_REF_GROUND: assert property (!sys_rst |=> pins.reference_grounded ==
    $past(cfg_active.single_ended && !cfg_active.guard_drive_enable &&
          !cfg_active.difference_charge_enable))
    else $error("Reference grounding wrong");
  AST_GUARD: assert property (!sys_rst && cfg_active.single_ended |=>
    pins.reference_follows_sense == $past(cfg_active.guard_drive_enable))
    else $error("Guard drive wrong");
  AST_DIFF_CHARGE: assert property (!sys_rst && cfg_active.single_ended |=>
    pins.reference_opposite_charge ==
    $past(cfg_active.difference_charge_enable && !cfg_active.guard_drive_enable))
    else $error("Opposite charge drive wrong");
  AST_START_BUSY: assert property (wr_en && addr == `CAPCAL_OFS_CTRL && wdata[0] && !busy
    |=> busy [*8])
    else $error("Start did not hold busy");
  AST_DONE_PULSE: assert property (done |-> $past(busy) && !busy ##1 !done)
    else $error("Done not a single pulse ending busy");
endmodule : capcal_top_assertions

bind capcal_top capcal_top_assertions i_chk (
  .clk(clk), .sys_rst(sys_rst), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
  .rdata(rdata), .pins(pins), .cfg_active(cfg_active), .busy(busy), .done(done)
);

// ==== dv/tb.sv ====
// Self-checking bench for the capacitive front end top
`include "capcal_defs.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic                     clk;
  logic                     sys_rst;
  logic [7:0]               addr;
  logic [15:0]              wdata;
  logic                     wr_en;
  logic                     rd_en;
  logic [15:0]              rdata;
  capcal_pkg::capcal_pins_t pins;
  capcal_pkg::capcal_cfg_t  cfg_active;
  logic                     busy;
  logic                     done;
  logic                     conflict;
  int                       mismatches;
  int                       num_checks;

  capcal_top i_dut (
    .clk(clk), .sys_rst(sys_rst), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .rdata(rdata), .pins(pins), .cfg_active(cfg_active),
    .busy(busy), .done(done)
  );
  capcal_sensor_model i_model (.clk(clk), .sys_rst(sys_rst), .pins(pins), .conflict_q(conflict));

  // ****************************************************************
  // Bus and compare helpers
  // ****************************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask : wr

  task automatic rdchk(input logic [7:0] a, input logic [15:0] exp);
    @(posedge clk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    chk({16'h0000, rdata}, {16'h0000, exp});
  endtask : rdchk

  task automatic end_of_test();
    $display("Checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_of_test

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic test_reset_regs();
    rdchk(`CAPCAL_OFS_CALOPT, 16'h0000);
    rdchk(`CAPCAL_OFS_FRONTEND, 16'h0080);
    rdchk(`CAPCAL_OFS_SUBMODE, 16'h0000);
    rdchk(8'h7F, 16'h0000);
    chk({30'h0, cfg_active.sensor_res}, 32'h2);
    chk({30'h0, cfg_active.temp_res}, 32'h1);
    $display("Test reset_regs done");
  endtask : test_reset_regs

  task automatic test_config();
    wr(`CAPCAL_OFS_CALOPT, 16'h0800);
    wr(`CAPCAL_OFS_FRONTEND, 16'hD400);
    wr(`CAPCAL_OFS_SUBMODE, 16'h0019);
    wr(`CAPCAL_OFS_RAW_LO, 16'h0001);
    wr(`CAPCAL_OFS_RAW_HI, 16'h0000);
    wr(`CAPCAL_OFS_COEF_LO, 16'h0000);
    wr(`CAPCAL_OFS_COEF_HI, 16'h00A0);
    rdchk(`CAPCAL_OFS_FRONTEND, 16'hD400);
    rdchk(`CAPCAL_OFS_SUBMODE, 16'h0019);
    rdchk(`CAPCAL_OFS_COEF_HI, 16'h00A0);
    $display("Test config done");
  endtask : test_config

  task automatic test_measure();
    time t0;
    int  n;
    int  cyc;
    wr(`CAPCAL_OFS_CTRL, 16'h0001);
    t0 = $time;
    wr(`CAPCAL_OFS_FRONTEND, 16'h0080);
    wr(`CAPCAL_OFS_CALOPT, 16'h0000);
    wr(`CAPCAL_OFS_CTRL, 16'h0001);
    chk({3'h0, cfg_active}, {3'h0, 6'h00, 5'h0A, 6'h14, 1'b1, 1'b1, 1'b0, 2'h0, 2'h1,
        1'b1, 1'b1, 2'h1, 1'b1});
    chk({27'h0, pins}, 32'h0000000A);
    rdchk(`CAPCAL_OFS_ACTIVE, 16'hD41D);
    rdchk(`CAPCAL_OFS_STATUS, 16'h0001);
    n = 0;
    while (done !== 1'b1 && n < 470000) begin
      @(posedge clk);
      #1;
      n++;
    end
    cyc = int'(($time - t0) / 4);
    chk({31'h0, done}, 32'h1);
    chk({31'h0, cyc >= 452500 && cyc <= 452504}, 32'h1);
    rdchk(`CAPCAL_OFS_RES_LO, 16'hFFFF);
    rdchk(`CAPCAL_OFS_RES_HI, 16'h01FF);
    rdchk(`CAPCAL_OFS_STATUS, 16'h0002);
    chk({31'h0, busy}, 32'h0);
    wr(`CAPCAL_OFS_CTRL, 16'h0004);
    rdchk(`CAPCAL_OFS_STATUS, 16'h0000);
    chk({31'h0, conflict}, 32'h0);
    $display("Test measure done");
  endtask : test_measure

  task automatic test_raw_abort();
    wr(`CAPCAL_OFS_CTRL, 16'h0003);
    rdchk(`CAPCAL_OFS_STATUS, 16'h0005);
    chk({27'h0, pins}, 32'h00000008);
    repeat (8) @(posedge clk);
    #1;
    chk({31'h0, busy}, 32'h1);
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    #1;
    chk({31'h0, busy}, 32'h0);
    chk({30'h0, cfg_active.sensor_res}, 32'h2);
    rdchk(`CAPCAL_OFS_STATUS, 16'h0000);
    rdchk(`CAPCAL_OFS_SUBMODE, 16'h0000);
    $display("Test raw_abort done");
  endtask : test_raw_abort

  // ****************************************************************
  // Clock, reset, sequence and watchdog
  // ****************************************************************
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  initial begin
    mismatches = 0;
    num_checks = 0;
    sys_rst    = 1'b1;
    addr       = 8'h00;
    wdata      = 16'h0000;
    wr_en      = 1'b0;
    rd_en      = 1'b0;
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    test_reset_regs();
    test_config();
    test_measure();
    test_raw_abort();
    end_of_test();
  end

  initial begin
    #2500000;
    mismatches++;
    end_of_test();
  end
endmodule : tb
